// File: common/cpu_regs_map.svh
/*
  constants for the core register set: flag positions, reset values, stack limits.
  assumes it is included by the package, ahead of the register module that uses its macros.
*/
// Summary of operation
// - flag register is 8 bits, bits 7..5 read one, reset 111x1xxx.
// - add and add-with-carry set half-carry on carry from bit 3 to bit 4.
// - mask bit set on interrupt entry or by software; cleared by software or return.
// - requests arriving while masked stay pending until the mask clears.
// - clearing the mask inside a handler lets pending requests in at once.
// - negative bit copies bit 7 of every arithmetic, logic or move result.
// - zero bit is set when that result is all zeros.
// - carry records overflow or borrow; set, reset, bit-test, shift and rotate write it.
// - whole flag register can be pushed and popped; single bits set and tested.
// - stack pointer addresses next free byte; decrement after push, increment before pop.
// - upper nine pointer bits fixed; reset or reset-pointer instruction loads 017f.
// - pointer wraps at both stack limits with no overflow indication.
// - pointer low byte is read and written by the ordinary load instruction.
// - interrupt entry writes program counter low byte first at the current pointer.
// - interrupt return pops context, incrementing the pointer for each byte.
// - a call uses two stack bytes, an interrupt uses five.
// - second index register is never saved or restored by interrupts.
// - program counter is 16 bits, low and high bytes, next instruction address.
// - six core registers are off the memory map; accumulator and indexes are 8 bits.
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH
`define FLAG_H_BIT 4
`define FLAG_I_BIT 3
`define FLAG_N_BIT 2
`define FLAG_Z_BIT 1
`define FLAG_C_BIT 0
`define FLAG_ONES 3'h7
`define FLAGS_RESET 8'he8
`define SP_FIXED_HIGH 9'h002
`define SP_RESET 16'h017f
`define SP_LOW_MASK 7'h7f
`define CALL_BYTES 3'h2
`define IRQ_BYTES 3'h5
`define PC_RESET 16'h0000
`endif

// File: common/cpu_regs_pkg.sv
/*
  types for the core register set.
  assumes cpu_regs_map.svh is on the include path.
*/
`include "cpu_regs_map.svh"
package cpu_regs_pkg;
  // register-file operation selected by the sequencer each cycle
  typedef enum logic [3:0] {
    op_none = 4'h0,
    op_alu = 4'h1,
    op_flag_write = 4'h2,
    op_push = 4'h3,
    op_pop = 4'h4,
    op_call = 4'h5,
    op_ret = 4'h6,
    op_irq_entry = 4'h7,
    op_irq_return = 4'h8,
    op_reset_sp = 4'h9,
    op_load_sp_low = 4'ha
  } reg_op_t;
  // sequence states for multi-byte stack transfers
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_push = 3'h1,
    st_pop = 3'h2
  } stack_state_t;
  // result of an operation handed in by the alu
  typedef struct packed {
    logic [7:0] value;
    logic upd_nz;
    logic upd_h;
    logic half_carry;
    logic upd_c;
    logic carry;
  } alu_result_t;
  // stack memory bus towards ram
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } stack_bus_t;
endpackage

// File: rtl/cpu_flags_and_stack_regs.sv
/*
  programmer-visible registers of the 8-bit core: accumulator, two index
  registers, program counter, flags and the 128-byte wrapping stack pointer,
  with the context save and restore sequences.
  assumes the sequencer issues one op per cycle only while busy is low, and
  that stack ram returns read data in the cycle its read strobe stands.
*/
`timescale 1ns/1ns
module cpu_flags_and_stack_regs
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // sequencer requests
  input wire reg_op_t op,
  input wire alu_result_t alu,
  input wire logic [7:0] op_data,
  input wire logic [15:0] op_addr,
  input wire logic [1:0] op_sel,
  input wire logic irq_request,
  // stack ram
  output stack_bus_t stack_bus,
  input wire logic [7:0] stack_rdata,
  // register view
  output logic busy,
  output logic irq_take,
  output logic [7:0] accumulator,
  output logic [7:0] index_x,
  output logic [7:0] index_y,
  output logic [15:0] program_counter,
  output logic [7:0] condition_flags,
  output logic [15:0] stack_pointer
);
  // op_sel for op_push/op_pop: 0 accumulator, 1 index_x, 2 index_y, 3 flags; op_alu with 3 writes no register
  logic [7:0] acc, next_acc, ix, next_ix, iy, next_iy, flags, next_flags;
  logic [15:0] pc, next_pc;
  logic [6:0] sp_low, next_sp_low;
  // sequence control: progress, length, kind and pending read
  stack_state_t state, next_state;
  logic [2:0] count, next_count;
  logic [2:0] total, next_total;
  logic is_irq, next_is_irq, rd_pend, next_rd_pend;
  logic [2:0] rd_idx, next_rd_idx;
  logic [15:0] target, next_target;
  stack_bus_t next_bus;
  logic [15:0] sp_full;

  assign sp_full = {`SP_FIXED_HIGH, sp_low};
  assign busy = (state != st_idle);
  // pending requests pass as soon as the mask drops and busy is low, no priority check
  assign irq_take = irq_request && !flags[`FLAG_I_BIT] && !busy;

  // byte pushed in sequence position n: pcl, pch, x, a, flags
  function automatic logic [7:0] push_byte(input logic [2:0] n, input logic irq);
    logic [7:0] b;
    b = 8'h00;
    case (n)
      3'h0: b = pc[7:0];
      3'h1: b = pc[15:8];
      3'h2: b = irq ? ix : 8'h00;
      3'h3: b = acc;
      3'h4: b = flags;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // next values of all register state
  always_comb
  begin
    next_acc = acc;
    next_ix = ix;
    next_iy = iy;
    next_flags = flags;
    next_pc = pc;
    next_sp_low = sp_low;
    next_state = state;
    next_count = count;
    next_total = total;
    next_is_irq = is_irq;
    next_rd_pend = 1'b0;
    next_rd_idx = rd_idx;
    next_target = target;
    // bus strobes are single-cycle pulses
    next_bus = '0;
    // capture data returning from a pop read
    if (rd_pend)
    begin
      if (state == st_pop && is_irq)
      begin
        // interrupt return order: flags, a, x, pch, pcl
        case (rd_idx)
          3'h0: next_flags = {`FLAG_ONES, stack_rdata[4:0]};
          3'h1: next_acc = stack_rdata;
          3'h2: next_ix = stack_rdata;
          3'h3: next_pc[15:8] = stack_rdata;
          default: next_pc[7:0] = stack_rdata;
        endcase
      end
      // subroutine return: high byte comes back first
      else if (state == st_pop)
      begin
        if (rd_idx == 3'h0)
          next_pc[15:8] = stack_rdata;
        else
          next_pc[7:0] = stack_rdata;
      end
      else
      begin
        // single pop lands in the register chosen when it was issued
        case (rd_idx[1:0])
          2'h0: next_acc = stack_rdata;
          2'h1: next_ix = stack_rdata;
          2'h2: next_iy = stack_rdata;
          default: next_flags = {`FLAG_ONES, stack_rdata[4:0]};
        endcase
      end
      // last restored byte ends the return sequence
      if (state == st_pop && rd_idx == total - 3'h1)
      begin
        next_state = st_idle;
        if (is_irq)
          next_flags[`FLAG_I_BIT] = 1'b0;
      end
    end
    case (state)
      st_idle:
      begin
        // new ops are only looked at while no sequence runs
        case (op)
          // alu result into the selected register, flags as the alu asks
          op_alu:
          begin
            case (op_sel)
              2'h0: next_acc = alu.value;
              2'h1: next_ix = alu.value;
              2'h2: next_iy = alu.value;
              default: next_acc = acc;
            endcase
            if (alu.upd_nz)
            begin
              next_flags[`FLAG_N_BIT] = alu.value[7];
              next_flags[`FLAG_Z_BIT] = (alu.value == 8'h00);
            end
            if (alu.upd_h)
              next_flags[`FLAG_H_BIT] = alu.half_carry;
            if (alu.upd_c)
              next_flags[`FLAG_C_BIT] = alu.carry;
            next_pc = op_addr;
          end
          op_flag_write:
            next_flags = {`FLAG_ONES, op_data[4:0]};
          // store first, then step down to the next free byte
          op_push:
          begin
            case (op_sel)
              2'h0: next_bus.wdata = acc;
              2'h1: next_bus.wdata = ix;
              2'h2: next_bus.wdata = iy;
              default: next_bus.wdata = flags;
            endcase
            next_bus.addr = sp_full;
            next_bus.write = 1'b1;
            next_sp_low = sp_low - 7'h01;
          end
          // step up first, then read the byte now pointed at
          op_pop:
          begin
            next_sp_low = sp_low + 7'h01;
            next_bus.addr = {`SP_FIXED_HIGH, sp_low + 7'h01};
            next_bus.read = 1'b1;
            next_rd_pend = 1'b1;
            next_rd_idx = {1'b0, op_sel}; // the sequencer may move on before data lands
          end
          // context save runs over the next cycles, busy holds off new ops
          op_call, op_irq_entry:
          begin
            next_state = st_push;
            next_count = 3'h0;
            next_is_irq = (op == op_irq_entry);
            next_total = (op == op_irq_entry) ? `IRQ_BYTES : `CALL_BYTES;
            next_target = op_addr;
          end
          // restore runs over the next cycles
          op_ret, op_irq_return:
          begin
            next_state = st_pop;
            next_count = 3'h0;
            next_is_irq = (op == op_irq_return);
            next_total = (op == op_irq_return) ? `IRQ_BYTES : `CALL_BYTES;
          end
          op_reset_sp:
            next_sp_low = `SP_LOW_MASK;
          op_load_sp_low:
            next_sp_low = op_data[6:0];
          default:
            next_pc = pc;
        endcase
      end
      // one context byte per cycle, lower address each time
      st_push:
      begin
        next_bus.addr = sp_full;
        next_bus.wdata = push_byte(count, is_irq);
        next_bus.write = 1'b1;
        next_sp_low = sp_low - 7'h01;
        next_count = count + 3'h1;
        // pc moves to the target only once the last byte is out
        if (count == total - 3'h1)
        begin
          next_state = st_idle;
          next_pc = target;
          if (is_irq)
            next_flags[`FLAG_I_BIT] = 1'b1;
        end
      end
      // one read per cycle; its data is captured at the next edge
      st_pop:
      begin
        if (count != total)
        begin
          next_sp_low = sp_low + 7'h01;
          next_bus.addr = {`SP_FIXED_HIGH, sp_low + 7'h01};
          next_bus.read = 1'b1;
          next_rd_pend = 1'b1;
          next_rd_idx = count;
          next_count = count + 3'h1;
        end
      end
      default:
        next_state = st_idle;
    endcase
  end

  // register the data registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      acc <= 8'h00;
      ix <= 8'h00;
      iy <= 8'h00;
      flags <= `FLAGS_RESET;
      pc <= `PC_RESET;
    end
    else
    begin
      acc <= next_acc;
      ix <= next_ix;
      iy <= next_iy;
      flags <= next_flags;
      pc <= next_pc;
    end
  end

  // register the stack pointer low bits
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sp_low <= `SP_LOW_MASK;
    end
    else
    begin
      sp_low <= next_sp_low;
    end
  end

  // register the sequence control and the stack bus
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= st_idle;
      count <= 3'h0;
      total <= 3'h0;
      is_irq <= 1'b0;
      rd_pend <= 1'b0;
      rd_idx <= 3'h0;
      target <= 16'h0000;
      stack_bus <= '0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      total <= next_total;
      is_irq <= next_is_irq;
      rd_pend <= next_rd_pend;
      rd_idx <= next_rd_idx;
      target <= next_target;
      stack_bus <= next_bus;
    end
  end

  // register view, off the memory map
  assign accumulator = acc;
  assign index_x = ix;
  assign index_y = iy;
  assign program_counter = pc;
  assign condition_flags = flags;
  assign stack_pointer = sp_full;
endmodule

// File: verif/cpu_regs_asserts.sv
/*
  port assertions for the core register set.
  assumes a bind onto cpu_flags_and_stack_regs.
*/
`timescale 1ns/1ns
module cpu_regs_asserts
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // requests
  input wire reg_op_t op,
  input wire alu_result_t alu,
  input wire logic irq_request,
  // observed outputs
  input wire stack_bus_t stack_bus,
  input wire logic busy,
  input wire logic irq_take,
  input wire logic [7:0] index_y,
  input wire logic [7:0] condition_flags,
  input wire logic [15:0] stack_pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // interrupt entry accepted, then five context writes
  sequence s_entry;
    op == op_irq_entry && !busy;
  endsequence
  sequence s_saves;
    (busy && !stack_bus.write) ##1 (busy && stack_bus.write) [*4]
      ##1 (!busy && stack_bus.write && condition_flags[3]);
  endsequence
  // interrupt return accepted, then six busy cycles and the mask cleared
  sequence s_return;
    op == op_irq_return && !busy;
  endsequence
  sequence s_restores;
    busy [*6] ##1 (!busy && !condition_flags[3]);
  endsequence
  AST_RET_SEQ: assert property (s_return |=> s_restores)
    else $error("return sequence wrong");
  AST_FLAG_ONES: assert property (condition_flags[7:5] == 3'h7)
    else $error("flag top bits not one");
  AST_SP_HIGH: assert property (stack_pointer[15:7] == 9'h002)
    else $error("pointer high bits moved");
  AST_PUSH: assert property (op == op_push && !busy |=> stack_bus.write
    && stack_bus.addr == $past(stack_pointer)
    && stack_pointer[6:0] == $past(stack_pointer[6:0]) - 7'h01)
    else $error("push write or decrement wrong");
  AST_POP: assert property (op == op_pop && !busy |=>
    stack_pointer[6:0] == $past(stack_pointer[6:0]) + 7'h01)
    else $error("pop increment wrong");
  AST_RESET_SP: assert property (op == op_reset_sp && !busy |=>
    stack_pointer == 16'h017f)
    else $error("pointer reset wrong");
  AST_NZ: assert property (op == op_alu && !busy && alu.upd_nz |=>
    condition_flags[2] == $past(alu.value[7])
    && condition_flags[1] == ($past(alu.value) == 8'h00))
    else $error("negative or zero flag wrong");
  AST_IRQ_TAKE: assert property (irq_take ==
    (irq_request && !condition_flags[3] && !busy))
    else $error("interrupt take wrong");
  AST_IRQ_SEQ: assert property (s_entry |=> s_saves)
    else $error("entry sequence wrong");
  AST_Y_KEEP: assert property (busy |=> $stable(index_y))
    else $error("second index moved");
endmodule
bind cpu_flags_and_stack_regs cpu_regs_asserts chk (.clk, .reset, .op, .alu,
  .irq_request, .stack_bus, .busy, .irq_take, .index_y, .condition_flags,
  .stack_pointer);

// File: verif/stack_ram_model.sv
/*
  stack ram model: 128 bytes, read data valid while the read strobe stands.
  assumes only the low seven address bits select a byte.
*/
`timescale 1ns/1ns
module stack_ram_model
  import cpu_regs_pkg::*;
(
  // clock
  input wire logic clk,
  // stack bus
  input wire stack_bus_t bus,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:127];
  // store on write
  always @(posedge clk)
  begin
    if (bus.write)
      mem[bus.addr[6:0]] <= bus.wdata;
  end
  // answer in the strobe's own cycle, inverted junk otherwise
  assign rdata = bus.read ? mem[bus.addr[6:0]] : ~mem[bus.addr[6:0]];
endmodule

// File: verif/tb_cpu_flags_and_stack_regs.sv
/*
  self-checking bench for the core register set.
  assumes the package, checker and ram model are compiled first.
*/
`timescale 1ns/1ns
module tb_cpu_flags_and_stack_regs;
  import cpu_regs_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  reg_op_t op = op_none;
  alu_result_t alu = '0;
  logic [7:0] op_data = 8'h00;
  logic [15:0] op_addr = 16'h0000;
  logic [1:0] op_sel = 2'h0;
  logic irq_request = 1'b0;
  stack_bus_t stack_bus;
  logic [7:0] stack_rdata, accumulator, index_x, index_y, condition_flags;
  logic busy, irq_take;
  logic [15:0] program_counter, stack_pointer;
  int fail_count = 0;
  int checks = 0;
  // device and stack ram
  cpu_flags_and_stack_regs dut (.clk, .reset, .op, .alu, .op_data, .op_addr, .op_sel,
    .irq_request, .stack_bus, .stack_rdata, .busy, .irq_take, .accumulator, .index_x,
    .index_y, .program_counter, .condition_flags, .stack_pointer);
  stack_ram_model ram (.clk, .bus(stack_bus), .rdata(stack_rdata));
  // 50 ns clock
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask
  task automatic results();
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one op, then wait out pop latency and busy
  task automatic go(reg_op_t o, logic [1:0] s, logic [7:0] d, logic [15:0] a);
    op = o;
    op_sel = s;
    op_data = d;
    op_addr = a;
    @(posedge clk);
    #5 op = op_none;
    op_sel = 2'h0; // a pop must have kept its own target by now
    repeat (3)
    begin
      @(posedge clk);
      #5;
    end
    repeat (8)
    begin
      if (busy)
      begin
        @(posedge clk);
        #5;
      end
    end
    @(posedge clk);
    #5;
  endtask
  task automatic calc(logic [1:0] s, logic [7:0] v, logic hc, logic cy);
    alu = '{v, 1'b1, 1'b1, hc, 1'b1, cy};
    go(op_alu, s, 8'h00, 16'habcd);
  endtask
  task automatic t_reset();
    chk("flags", condition_flags, 8'he8);
    chk("sp", stack_pointer, 16'h017f);
  endtask
  task automatic t_flags();
    calc(2'h0, 8'h80, 1'b1, 1'b1);
    chk("flags", condition_flags, 8'hfd);
    calc(2'h0, 8'h00, 1'b0, 1'b0);
    chk("flags", condition_flags, 8'hea);
    go(op_flag_write, 2'h0, 8'h1f, 16'h0000);
    chk("flags", condition_flags, 8'hff);
  endtask
  task automatic t_irq();
    calc(2'h2, 8'h77, 1'b0, 1'b0);
    calc(2'h0, 8'h3c, 1'b0, 1'b0);
    calc(2'h1, 8'h5a, 1'b0, 1'b0);
    go(op_flag_write, 2'h0, 8'h01, 16'h0000);
    irq_request = 1'b1;
    #1 chk("take", irq_take, 1'b1);
    go(op_irq_entry, 2'h0, 8'h00, 16'h1234);
    chk("sp", stack_pointer, 16'h017a);
    chk("pc", program_counter, 16'h1234);
    chk("take", irq_take, 1'b0);
    chk("pcl", ram.mem[127], 8'hcd);
    chk("pch", ram.mem[126], 8'hab);
    chk("x", ram.mem[125], 8'h5a);
    chk("a", ram.mem[124], 8'h3c);
    chk("cc", ram.mem[123], 8'he1);
    alu = '{8'h00, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    go(op_alu, 2'h0, 8'h00, 16'h4321);
    go(op_alu, 2'h1, 8'h00, 16'h4321);
    go(op_irq_return, 2'h0, 8'h00, 16'h0000);
    chk("sp", stack_pointer, 16'h017f);
    chk("a", accumulator, 8'h3c);
    chk("x", index_x, 8'h5a);
    chk("y", index_y, 8'h77);
    chk("pc", program_counter, 16'habcd);
    chk("flags", condition_flags, 8'he1);
    chk("take", irq_take, 1'b1);
    irq_request = 1'b0;
  endtask
  task automatic t_call();
    go(op_alu, 2'h3, 8'h00, 16'h5a3c);
    go(op_call, 2'h0, 8'h00, 16'h2000);
    chk("sp", stack_pointer, 16'h017d);
    chk("pc", program_counter, 16'h2000);
    chk("pcl", ram.mem[127], 8'h3c);
    chk("pch", ram.mem[126], 8'h5a);
    go(op_ret, 2'h0, 8'h00, 16'h0000);
    chk("pc", program_counter, 16'h5a3c);
    chk("sp", stack_pointer, 16'h017f);
  endtask
  task automatic t_stack();
    go(op_load_sp_low, 2'h0, 8'h00, 16'h0000);
    chk("sp", stack_pointer, 16'h0100);
    go(op_push, 2'h0, 8'h00, 16'h0000);
    chk("sp", stack_pointer, 16'h017f);
    go(op_pop, 2'h2, 8'h00, 16'h0000);
    chk("sp", stack_pointer, 16'h0100);
    chk("y", index_y, 8'h3c);
    go(op_reset_sp, 2'h0, 8'h00, 16'h0000);
    chk("sp", stack_pointer, 16'h017f);
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #5 reset = 1'b0;
    t_reset();
    t_flags();
    t_irq();
    t_call();
    t_stack();
    results();
  end
  // watchdog
  initial
  begin
    repeat (3000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
